/* rtl/twcp_pkg.sv */
package twcp_pkg;
   // ***************************
   // Frame layout and commands
   // ***************************
   localparam int FRAME_BITS = 16;
   localparam int HEAD_BITS = 8;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   localparam int RW_POS = 6;
   localparam int LOW_RUN_BITS = 32;
   localparam logic [15:0] CMD_IF_RESET = 16'h8D00;
   localparam logic [15:0] CMD_IF_RELEASE = 16'h8D02;
   localparam logic [15:0] CMD_CORE_RESET = 16'hBD01;

   // ***************************
   // Timing
   // ***************************
   localparam int CLOCK_PERIOD_NS = 40;
   localparam int DATA_RELEASE_NS = 15000;
   localparam int SETTLE_TIME_NS = 1000000;
   localparam int STOP_TIMEOUT_NS = 20000000;
   // Longest time rounds down, least time rounds up
   localparam int RELEASE_CYCLES = DATA_RELEASE_NS / CLOCK_PERIOD_NS;
   localparam int SETTLE_CYCLES_DFLT = (SETTLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int STOP_CYCLES_DFLT = (STOP_TIMEOUT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } twcp_reg_req_t;

   typedef enum logic {TWCP_HUNT, TWCP_SHIFT} twcp_state_t;
endpackage

/* rtl/twcp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module twcp_sync (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic pin,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta_reg;
   logic sync_reg;
   logic prev_reg;
   // Edges stay masked until the history holds real pin samples, so the reset level cannot fake an edge
   logic [2:0] live_reg;

   // Two flops before any logic; edges come from the settled copy only
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
         live_reg <= 3'h0;
      end else begin
         meta_reg <= pin;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
         live_reg <= {live_reg[1:0], 1'b1};
      end
   end

   assign level = sync_reg;
   assign rise = live_reg[2] & sync_reg & ~prev_reg;
   assign fall = live_reg[2] & ~sync_reg & prev_reg;
endmodule
`default_nettype wire

/* rtl/twcp_port.sv */
// Behaviour
// - Host launches on clock rise; device captures on next clock fall.
// - Data line returns idle within 15,000 ns after the last rise.
// - Interface reset is 32 low cycles then 0x8D00, 48 cycles total.
// - Interface reset resets port only; data edges cannot start transmission.
// - Rising-start mode: data idles low, no first-clock delay limit.
// - Pattern 0x8D02 disables port and re-arms edge start until reset.
// - Pattern 0xBD01 resets all but the port and runs calibration.
// - Host waits 1 ms after core reset; device then sleeps.
// - Sleep after data low for stop timeout or after settle time following core reset.
// - Register frame is 16 cycles: one, rw flag, address, data byte.
// - Flag one reads and device drives data; zero writes the byte.
`timescale 1ns/1ps
`default_nettype none
module twcp_port #(
   parameter int SETTLE_CYCLES = twcp_pkg::SETTLE_CYCLES_DFLT,
   parameter int STOP_CYCLES = twcp_pkg::STOP_CYCLES_DFLT
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic serial_clk,
   input wire logic data_in,
   output logic data_out,
   output logic data_oe,
   input wire logic start_edge_select,
   output twcp_pkg::twcp_reg_req_t reg_req,
   output logic reg_req_valid,
   input wire logic [twcp_pkg::DATA_W-1:0] reg_rd_data,
   output logic core_reset,
   output logic calib_start,
   output logic port_enabled,
   output logic edge_armed,
   output logic tx_active,
   output logic asleep
);
   import twcp_pkg::*;

   // ***************************
   // Pin sampling
   // ***************************
   logic sck_rise, sck_fall;
   logic dat_lvl, dat_rise, dat_fall;

   twcp_sync u_sck_sync (
      .clock(clock),
      .rst_b(rst_b),
      .pin(serial_clk),
      .level(),
      .rise(sck_rise),
      .fall(sck_fall)
   );

   twcp_sync u_dat_sync (
      .clock(clock),
      .rst_b(rst_b),
      .pin(data_in),
      .level(dat_lvl),
      .rise(dat_rise),
      .fall(dat_fall)
   );

   // ***************************
   // Frame capture
   // ***************************
   twcp_state_t state_reg;
   logic [FRAME_BITS-1:0] shift_reg;
   logic [4:0] bit_cnt_reg;
   logic [5:0] low_run_reg;
   logic armed_reg;
   logic rd_active_reg;
   logic [DATA_W-1:0] out_shift_reg;
   logic rd_load_reg;
   logic [8:0] rel_cnt_reg;
   logic port_en_reg, edge_arm_reg, tx_reg, sleep_reg;
   logic core_rst_reg, calib_reg;
   logic settle_busy_reg;
   logic [31:0] settle_cnt_reg;
   logic [31:0] stop_cnt_reg;
   twcp_reg_req_t req_reg;
   logic req_valid_reg;
   logic dout_reg, doe_reg;

   wire [FRAME_BITS-1:0] word_next = {shift_reg[FRAME_BITS-2:0], dat_lvl};
   wire in_shift = (state_reg == TWCP_SHIFT);
   wire frame_start = sck_fall && !in_shift && dat_lvl;
   wire frame_done = sck_fall && in_shift && (bit_cnt_reg == 5'(FRAME_BITS - 1));
   wire head_done = sck_fall && in_shift && (bit_cnt_reg == 5'(HEAD_BITS - 1));
   wire run_full = (low_run_reg == 6'(LOW_RUN_BITS));
   wire is_if_reset = frame_done && armed_reg && (word_next == CMD_IF_RESET);
   wire is_release = frame_done && port_en_reg && (word_next == CMD_IF_RELEASE);
   wire is_core_rst = frame_done && port_en_reg && (word_next == CMD_CORE_RESET);
   wire is_special = (word_next == CMD_IF_RESET) || (word_next == CMD_IF_RELEASE) || (word_next == CMD_CORE_RESET);
   wire is_write = frame_done && port_en_reg && !is_special && !word_next[HEAD_BITS + RW_POS];
   wire is_read = head_done && port_en_reg && word_next[RW_POS];
   wire rel_expire = (rel_cnt_reg == 9'(RELEASE_CYCLES - 1));
   wire start_edge = start_edge_select ? dat_rise : dat_fall;
   wire tx_start = edge_arm_reg && sleep_reg && !tx_reg && start_edge;
   wire stop_hit = tx_reg && !dat_lvl && (stop_cnt_reg == 32'(STOP_CYCLES - 1));
   wire settle_end = settle_busy_reg && (settle_cnt_reg == 32'd0);

   // Capture on the falling serial clock edge, after synchronising
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= TWCP_HUNT;
         shift_reg <= 16'h0000;
         bit_cnt_reg <= 5'h00;
         armed_reg <= 1'b0;
      end else if (frame_start) begin
         state_reg <= TWCP_SHIFT;
         shift_reg <= 16'h0001;
         bit_cnt_reg <= 5'h01;
         armed_reg <= run_full;
      end else if (sck_fall && in_shift) begin
         shift_reg <= word_next;
         bit_cnt_reg <= bit_cnt_reg + 5'h01;
         if (frame_done) begin
            state_reg <= TWCP_HUNT;
         end
      end
   end

   // Run of low bits between frames; saturates at the reset preamble length
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         low_run_reg <= 6'h00;
      end else if (sck_fall && !in_shift) begin
         low_run_reg <= dat_lvl ? 6'h00 : (run_full ? low_run_reg : low_run_reg + 6'h01);
      end else if (sck_fall) begin
         low_run_reg <= 6'h00;
      end
   end

   // ***************************
   // Command decode
   // ***************************
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         port_en_reg <= 1'b1;
         edge_arm_reg <= 1'b0;
      end else if (is_if_reset) begin
         port_en_reg <= 1'b1;
         edge_arm_reg <= 1'b0;
      end else if (is_release) begin
         port_en_reg <= 1'b0;
         edge_arm_reg <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         req_reg <= '0;
         req_valid_reg <= 1'b0;
      end else begin
         req_valid_reg <= is_write || is_read;
         if (is_write) begin
            req_reg <= '{write: 1'b1, addr: word_next[HEAD_BITS+ADDR_W-1:HEAD_BITS], data: word_next[DATA_W-1:0]};
         end else if (is_read) begin
            req_reg <= '{write: 1'b0, addr: word_next[ADDR_W-1:0], data: 8'h00};
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         core_rst_reg <= 1'b0;
         calib_reg <= 1'b0;
      end else begin
         core_rst_reg <= is_core_rst;
         calib_reg <= is_core_rst;
      end
   end

   // ***************************
   // Read data return
   // ***************************
   // The register answer is taken in the same cycle as the request pulse
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rd_active_reg <= 1'b0;
         rd_load_reg <= 1'b0;
         out_shift_reg <= 8'h00;
         dout_reg <= 1'b0;
         doe_reg <= 1'b0;
      end else begin
         rd_load_reg <= is_read;
         if (is_read) begin
            rd_active_reg <= 1'b1;
         end else if (frame_done) begin
            rd_active_reg <= 1'b0;
         end
         if (rd_load_reg) begin
            out_shift_reg <= reg_rd_data;
         end else if (sck_rise && rd_active_reg) begin
            dout_reg <= out_shift_reg[DATA_W-1];
            doe_reg <= 1'b1;
            out_shift_reg <= {out_shift_reg[DATA_W-2:0], 1'b0};
         end else if ((sck_rise && !rd_active_reg) || rel_expire) begin
            doe_reg <= 1'b0;
            dout_reg <= 1'b0;
         end
      end
   end

   // Fallback release in case the host never raises the clock again
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rel_cnt_reg <= 9'h000;
      end else if (doe_reg && !rd_active_reg && !rel_expire) begin
         rel_cnt_reg <= rel_cnt_reg + 9'h001;
      end else begin
         rel_cnt_reg <= 9'h000;
      end
   end

   // ***************************
   // Transmission and sleep
   // ***************************
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         settle_busy_reg <= 1'b0;
         settle_cnt_reg <= 32'h00000000;
      end else if (core_rst_reg) begin
         settle_busy_reg <= 1'b1;
         settle_cnt_reg <= 32'(SETTLE_CYCLES - 1);
      end else if (settle_busy_reg) begin
         settle_busy_reg <= !settle_end;
         settle_cnt_reg <= settle_end ? settle_cnt_reg : settle_cnt_reg - 32'h00000001;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         stop_cnt_reg <= 32'h00000000;
      end else if (tx_reg && !dat_lvl && !stop_hit) begin
         stop_cnt_reg <= stop_cnt_reg + 32'h00000001;
      end else begin
         stop_cnt_reg <= 32'h00000000;
      end
   end

   // Edges start a transmission only while the port is released
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         tx_reg <= 1'b0;
         sleep_reg <= 1'b1;
      end else if (core_rst_reg || settle_busy_reg) begin
         tx_reg <= 1'b0;
         sleep_reg <= settle_end;
      end else if (stop_hit) begin
         tx_reg <= 1'b0;
         sleep_reg <= 1'b1;
      end else if (tx_start) begin
         tx_reg <= 1'b1;
         sleep_reg <= 1'b0;
      end
   end

   assign data_out = dout_reg;
   assign data_oe = doe_reg;
   assign reg_req = req_reg;
   assign reg_req_valid = req_valid_reg;
   assign core_reset = core_rst_reg;
   assign calib_start = calib_reg;
   assign port_enabled = port_en_reg;
   assign edge_armed = edge_arm_reg;
   assign tx_active = tx_reg;
   assign asleep = sleep_reg;

   // ***************************
   // Checks
   // ***************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   a_iface_reset_locks: assert property (is_if_reset |=> port_en_reg && !edge_arm_reg)
      else $error("interface reset did not lock edge start");
   a_no_armed_start: assert property ((!edge_arm_reg && !tx_reg && !settle_busy_reg) |=> !tx_reg)
      else $error("transmission started while port held");
   a_release_arms: assert property (is_release |=> !port_en_reg && edge_arm_reg)
      else $error("release command did not arm edge start");
   a_core_pulse: assert property (is_core_rst |=> core_rst_reg && calib_reg ##1 !core_rst_reg && !tx_reg)
      else $error("core reset pulse wrong");
   a_settle_sleep: assert property (settle_end |=> sleep_reg && !settle_busy_reg)
      else $error("no sleep after settle time");
   a_stop_sleep: assert property ((stop_hit && !core_rst_reg && !settle_busy_reg) |=> sleep_reg && !tx_reg)
      else $error("stop timeout did not sleep");
   a_capture_fall: assert property ((sck_fall && in_shift) |=> shift_reg[0] == $past(dat_lvl))
      else $error("bit not captured on clock fall");
   a_release_bound: assert property ((doe_reg && !rd_active_reg) |-> rel_cnt_reg < 9'(RELEASE_CYCLES))
      else $error("data line held too long");
   a_read_request: assert property (is_read |=> reg_req_valid && !reg_req.write ##2 !reg_req_valid)
      else $error("read request not issued");
   a_frame_length: assert property (frame_done |=> !in_shift && shift_reg == $past(word_next))
      else $error("frame did not close after sixteen bits");
endmodule
`default_nettype wire

/* dv/twcp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module twcp_host (
   input wire logic clock,
   input wire logic data_out,
   input wire logic data_oe,
   output logic serial_clk,
   output logic data_wire
);
   // ****************
   // Host side
   // ****************
   logic host_d = 1'b0;
   logic host_oe = 1'b1;
   logic last_w = 1'b0;
   logic [7:0] rd_byte = 8'h00;
   initial serial_clk = 1'b1;
   // No pull on the line, so a released wire shows the inverse of its last level
   assign data_wire = data_oe ? data_out : (host_oe ? host_d : ~last_w);
   always @(posedge clock) last_w <= data_wire;
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   // Eight cycles a bit keeps the serial period at 320 ns
   task automatic put_bit(input logic b);
      host_d <= b;
      cyc(4);
      serial_clk <= 1'b0;
      cyc(4);
      serial_clk <= 1'b1;
   endtask
   task automatic frame(input logic [15:0] v);
      for (int i = 15; i >= 0; i--) put_bit(v[i]);
   endtask
   task automatic if_reset();
      repeat (32) put_bit(1'b0);
      frame(16'h8D00);
   endtask
   task automatic read_reg(input logic [5:0] a);
      logic [7:0] h;
      h = {2'b11, a};
      for (int i = 7; i >= 0; i--) put_bit(h[i]);
      for (int i = 7; i >= 0; i--) begin
         host_oe <= 1'b0;
         cyc(4);
         serial_clk <= 1'b0;
         cyc(1);
         rd_byte[i] = data_wire;
         cyc(3);
         serial_clk <= 1'b1;
      end
      cyc(8);
      host_oe <= 1'b1;
      host_d <= 1'b0;
      cyc(1);
   endtask
endmodule
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import twcp_pkg::*;
   // ****************
   // Harness
   // ****************
   localparam int SETTLE = 20;
   localparam int STOP = 50;
   logic clock = 1'b0;
   logic rst_b;
   logic start_edge_select;
   logic [7:0] reg_rd_data;
   logic serial_clk, data_wire, data_out, data_oe, reg_req_valid, core_reset, calib_start;
   logic port_enabled, edge_armed, tx_active, asleep;
   twcp_reg_req_t reg_req;
   int n_errors = 0;
   int num_checks = 0;
   logic [16:0] notes[$];
   logic [16:0] note_v;
   always #20 clock = ~clock;
   twcp_port #(.SETTLE_CYCLES(SETTLE), .STOP_CYCLES(STOP)) twcp_port_i (.clock(clock), .rst_b(rst_b),
      .serial_clk(serial_clk), .data_in(data_wire), .data_out(data_out), .data_oe(data_oe),
      .start_edge_select(start_edge_select), .reg_req(reg_req), .reg_req_valid(reg_req_valid),
      .reg_rd_data(reg_rd_data), .core_reset(core_reset), .calib_start(calib_start),
      .port_enabled(port_enabled), .edge_armed(edge_armed), .tx_active(tx_active), .asleep(asleep));
   twcp_host twcp_host_i (.clock(clock), .data_out(data_out), .data_oe(data_oe),
      .serial_clk(serial_clk), .data_wire(data_wire));
   task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Order: port_enabled, edge_armed, tx_active, asleep
   task automatic st(input logic [3:0] e);
      check("status", {13'h0, port_enabled, edge_armed, tx_active, asleep}, {13'h0, e});
   endtask
   // Pulses are looked at mid-cycle, clear of the edge that launches them
   always @(negedge clock) begin
      if (rst_b && (reg_req_valid === 1'b1 || core_reset === 1'b1)) begin
         if (notes.size() == 0) begin
            check("unexpected pulse", 17'h1, 17'h0);
         end else begin
            note_v = notes.pop_front();
            case (note_v[16:15])
               2'b10: check("core reset", {2'b10, 14'h0, calib_start}, note_v);
               2'b01: check("read request", {2'b01, reg_req[14:8], 8'h00}, note_v);
               default: check("write request", {2'b00, reg_req}, note_v);
            endcase
         end
      end
   end
   // ****************
   // Scenarios
   // ****************
   task automatic core_rst();
      notes.push_back({2'b10, 15'h1});
      twcp_host_i.frame(16'hBD01);
      twcp_host_i.cyc(SETTLE + 10);
      st(4'b1001);
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      notes.push_back({2'b00, 1'b1, a, d});
      twcp_host_i.frame({2'b10, a, d});
      twcp_host_i.cyc(8);
   endtask
   task automatic rd(input logic [5:0] a);
      logic [7:0] v;
      v = 8'($urandom);
      reg_rd_data <= v;
      notes.push_back({2'b01, 1'b0, a, 8'h00});
      twcp_host_i.read_reg(a);
      check("read data", {9'h0, twcp_host_i.rd_byte}, {9'h0, v});
      check("drive enable", {16'h0, data_oe}, 17'h0);
   endtask
   task automatic end_sim();
      $display("Checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge clock);
      n_errors++;
      end_sim();
   end
   initial begin
      logic [5:0] a;
      int seed;
      rst_b <= 1'b0;
      start_edge_select <= 1'b1;
      reg_rd_data <= 8'h00;
      seed = $urandom(32'h4B7A);
      repeat (12) @(posedge clock);
      rst_b <= 1'b1;
      twcp_host_i.cyc(3);
      st(4'b1001);
      twcp_host_i.if_reset();
      core_rst();
      $display("Test power-up done");
      // Bit 0 cleared keeps writes clear of the special patterns
      for (int i = 0; i < 4; i++) begin
         a = 6'($urandom) & 6'h3E;
         wr(a, 8'($urandom));
         rd(i == 3 ? 6'h3F : a);
      end
      $display("Test register access done");
      for (int m = 1; m >= 0; m--) begin
         start_edge_select <= m[0];
         twcp_host_i.if_reset();
         st(4'b1001);
         twcp_host_i.frame(16'h8D02);
         twcp_host_i.cyc(4);
         st(4'b0101);
         twcp_host_i.host_d <= ~m[0];
         twcp_host_i.cyc(8);
         st(4'b0101);
         twcp_host_i.host_d <= m[0];
         twcp_host_i.cyc(6);
         st(4'b0110);
         twcp_host_i.host_d <= 1'b0;
         twcp_host_i.cyc(STOP + 10);
         st(4'b0101);
         twcp_host_i.if_reset();
         core_rst();
         $display("Test transmission mode %0d done", m);
      end
      check("pending notes", 17'(notes.size()), 17'h0);
      end_sim();
   end
endmodule
`default_nettype wire
